/* File: src/upsys_pkg.sv */
// Package: shared types and constants for the upstream error and bus request block
package upsys_pkg;

    // ****************************************
    // Fault sources
    // ****************************************
    localparam int NUM_FAULTS     = 9;
    localparam int F_ADDR_PAR     = 0;
    localparam int F_PW_DATA_PAR  = 2;
    localparam int F_DOWN_SERR    = 1;
    localparam int F_PW_MABORT    = 3;
    localparam int F_PW_TABORT    = 4;
    localparam int F_PW_DISCARD   = 5;
    localparam int F_DW_DISCARD   = 6;
    localparam int F_DR_DISCARD   = 7;
    localparam int F_DT_TIMEOUT   = 8;

    // ****************************************
    // Timing, reset and park values
    // ****************************************
    localparam int          SERR_PULSE_CYCLES = 1;
    localparam logic        REQ_RESET         = 1'b0;
    localparam logic [31:0] PARK_AD_VALUE     = 32'h0000_0000;
    localparam logic [3:0]  PARK_CBE_VALUE    = 4'h0;

    // Fault events from the bridge core, one-cycle pulses
    typedef struct packed {
        logic dt_timeout;
        logic dr_discard;
        logic dw_discard;
        logic pw_discard;
        logic pw_tabort;
        logic pw_mabort;
        logic pw_data_par;
        logic down_serr;
        logic addr_par;
    } fault_s;

    // Parked drive on address/data, command and parity
    typedef struct packed {
        logic [31:0] ad;
        logic [3:0]  cbe;
        logic        par;
        logic        ad_oe;
        logic        par_oe;
    } park_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_REQ,
        ST_OWN,
        ST_PARK
    } bus_state_e;

endpackage

/* File: src/upsys_err_req.sv */
// Upstream system error reporting and bus request/grant/park logic
`timescale 1ns/1ns
`default_nettype none
module upsys_err_req
    import upsys_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire fault_s      fault,
    input  wire logic        down_serr_n_pin,
    input  wire logic        serr_n_in,
    input  wire logic        gnt_n_pin,
    input  wire logic        frame_n_pin,
    input  wire logic        irdy_n_pin,
    input  wire logic        need_bus,
    input  wire logic        xfer_done,
    output logic             serr_n_out,
    output logic             serr_n_oe,
    output logic             req_n,
    output logic             start,
    output park_s            park
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [2:0] dserr_sync_reg;
    logic [2:0] gnt_sync_reg;
    logic [2:0] frame_sync_reg;
    logic [2:0] irdy_sync_reg;
    logic       dserr_lvl_reg;
    logic       gnt_lvl_reg;
    logic       frame_lvl_reg;
    logic       irdy_lvl_reg;

    // A change counts once stages two and three agree
    function automatic logic filt(input logic [2:0] s, input logic prev);
        return (s[1] == s[2]) ? s[2] : prev;
    endfunction

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dserr_sync_reg <= 3'h7;
            gnt_sync_reg   <= 3'h7;
            frame_sync_reg <= 3'h7;
            irdy_sync_reg  <= 3'h7;
            dserr_lvl_reg  <= 1'b1;
            gnt_lvl_reg    <= 1'b1;
            frame_lvl_reg  <= 1'b1;
            irdy_lvl_reg   <= 1'b1;
        end else begin
            dserr_sync_reg <= {dserr_sync_reg[1:0], down_serr_n_pin};
            gnt_sync_reg   <= {gnt_sync_reg[1:0], gnt_n_pin};
            frame_sync_reg <= {frame_sync_reg[1:0], frame_n_pin};
            irdy_sync_reg  <= {irdy_sync_reg[1:0], irdy_n_pin};
            dserr_lvl_reg  <= filt(dserr_sync_reg, dserr_lvl_reg);
            gnt_lvl_reg    <= filt(gnt_sync_reg, gnt_lvl_reg);
            frame_lvl_reg  <= filt(frame_sync_reg, frame_lvl_reg);
            irdy_lvl_reg   <= filt(irdy_sync_reg, irdy_lvl_reg);
        end
    end

    wire granted  = !gnt_lvl_reg;
    wire bus_idle = frame_lvl_reg && irdy_lvl_reg;

    // ****************************************
    // System error
    // ****************************************
    wire addr_par_hit  = fault.addr_par;
    wire pw_par_hit    = fault.pw_data_par;
    // Core may also report a downstream fault as an event
    wire down_hit      = !dserr_lvl_reg | fault.down_serr;
    wire pw_ma_hit     = fault.pw_mabort;
    wire pw_ta_hit     = fault.pw_tabort;
    wire pw_disc_hit   = fault.pw_discard;
    wire dw_disc_hit   = fault.dw_discard;
    wire dr_disc_hit   = fault.dr_discard;
    wire dt_to_hit     = fault.dt_timeout;
    wire serr_any = addr_par_hit | pw_par_hit | down_hit | pw_ma_hit | pw_ta_hit
                  | pw_disc_hit | dw_disc_hit | dr_disc_hit | dt_to_hit;

    // Open drain: data stays low, only the enable moves
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            serr_n_oe <= 1'b0;
        end else begin
            serr_n_oe <= serr_any;
        end
    end

    always_ff @(posedge clk) begin
        serr_n_out <= 1'b0;
    end

    // ****************************************
    // Request, grant and park
    // ****************************************
    bus_state_e state_reg;
    bus_state_e state_next;

    // Grant and idle pass the pin filter, so start trails the pins by five edges
    wire may_start = granted && bus_idle && (state_reg == ST_REQ);
    wire park_now  = granted && bus_idle && !need_bus && (state_reg != ST_OWN);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (need_bus) begin
                    state_next = ST_REQ;
                end else if (park_now) begin
                    state_next = ST_PARK;
                end
            end
            ST_REQ: begin
                if (may_start) begin
                    state_next = ST_OWN;
                end else if (!need_bus) begin
                    state_next = ST_IDLE;
                end
            end
            ST_OWN: begin
                if (xfer_done) begin
                    state_next = ST_IDLE;
                end
            end
            ST_PARK: begin
                if (need_bus) begin
                    state_next = ST_REQ;
                end else if (!granted || !bus_idle) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    wire req_next = (state_next == ST_REQ);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            req_n     <= !REQ_RESET;
            start     <= 1'b0;
        end else begin
            state_reg <= state_next;
            req_n     <= !req_next;
            start     <= may_start;
        end
    end

    // Parity enable trails address/data by one cycle on entry to park, and drops with it on exit
    wire parking = (state_next == ST_PARK);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            park <= '0;
        end else begin
            park.ad     <= PARK_AD_VALUE;
            park.cbe    <= PARK_CBE_VALUE;
            park.par    <= ^{PARK_AD_VALUE, PARK_CBE_VALUE};
            park.ad_oe  <= parking;
            park.par_oe <= parking && park.ad_oe;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    property p_serr_low_only;
        @(posedge clk) disable iff (!rst_n) serr_n_oe |-> !serr_n_out;
    endproperty
    a_serr_low_only: assert property (p_serr_low_only) else $error("serr driven high");

    property p_addr_par;
        @(posedge clk) disable iff (!rst_n) fault.addr_par |=> serr_n_oe;
    endproperty
    a_addr_par: assert property (p_addr_par) else $error("addr parity not reported");

    property p_pw_par;
        @(posedge clk) disable iff (!rst_n) fault.pw_data_par |=> serr_n_oe;
    endproperty
    a_pw_par: assert property (p_pw_par) else $error("posted parity not reported");

    property p_down;
        @(posedge clk) disable iff (!rst_n) (!dserr_lvl_reg || fault.down_serr) |=> serr_n_oe;
    endproperty
    a_down: assert property (p_down) else $error("downstream serr not passed");

    property p_pw_mabort;
        @(posedge clk) disable iff (!rst_n) fault.pw_mabort |=> serr_n_oe;
    endproperty
    a_pw_mabort: assert property (p_pw_mabort) else $error("master abort not reported");

    property p_pw_tabort;
        @(posedge clk) disable iff (!rst_n) fault.pw_tabort |=> serr_n_oe;
    endproperty
    a_pw_tabort: assert property (p_pw_tabort) else $error("target abort not reported");

    property p_pw_discard;
        @(posedge clk) disable iff (!rst_n) fault.pw_discard |=> serr_n_oe;
    endproperty
    a_pw_discard: assert property (p_pw_discard) else $error("posted discard not reported");

    property p_dw_discard;
        @(posedge clk) disable iff (!rst_n) fault.dw_discard |=> serr_n_oe;
    endproperty
    a_dw_discard: assert property (p_dw_discard) else $error("delayed write discard not reported");

    property p_dr_discard;
        @(posedge clk) disable iff (!rst_n) fault.dr_discard |=> serr_n_oe;
    endproperty
    a_dr_discard: assert property (p_dr_discard) else $error("delayed read discard not reported");

    property p_dt_timeout;
        @(posedge clk) disable iff (!rst_n) fault.dt_timeout |=> serr_n_oe;
    endproperty
    a_dt_timeout: assert property (p_dt_timeout) else $error("master timeout not reported");

    property p_no_spurious;
        @(posedge clk) disable iff (!rst_n) !serr_any |=> !serr_n_oe;
    endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("spurious serr");

    property p_start_ok;
        @(posedge clk) disable iff (!rst_n) start |-> $past(granted) && $past(bus_idle);
    endproperty
    a_start_ok: assert property (p_start_ok) else $error("start without grant or idle bus");

    property p_req;
        @(posedge clk) disable iff (!rst_n) (state_reg == ST_REQ) |-> !req_n;
    endproperty
    a_req: assert property (p_req) else $error("request missing");

    property p_park_par;
        @(posedge clk) disable iff (!rst_n) park.par_oe |-> $past(park.ad_oe);
    endproperty
    a_park_par: assert property (p_park_par) else $error("parity parked early");

    property p_park_unreq;
        @(posedge clk) disable iff (!rst_n) park.ad_oe |-> req_n;
    endproperty
    a_park_unreq: assert property (p_park_unreq) else $error("park while requesting");

    property p_start_pulse;
        @(posedge clk) disable iff (!rst_n) start |=> !start;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");

    property p_start_req;
        @(posedge clk) disable iff (!rst_n) start |-> !$past(req_n);
    endproperty
    a_start_req: assert property (p_start_req) else $error("start without request");

    property p_park_grant;
        @(posedge clk) disable iff (!rst_n) park.ad_oe |-> $past(granted);
    endproperty
    a_park_grant: assert property (p_park_grant) else $error("park without grant");

    property p_park_release;
        @(posedge clk) disable iff (!rst_n) (park.ad_oe && !granted) |=> !park.ad_oe;
    endproperty
    a_park_release: assert property (p_park_release) else $error("park held after grant loss");

    property p_park_values;
        @(posedge clk) disable iff (!rst_n)
            park.ad_oe |-> (park.ad == PARK_AD_VALUE) && (park.cbe == PARK_CBE_VALUE);
    endproperty
    a_park_values: assert property (p_park_values) else $error("parked levels wrong");

    property p_park_par_value;
        @(posedge clk) disable iff (!rst_n) park.par_oe |-> (park.par == ^{PARK_AD_VALUE, PARK_CBE_VALUE});
    endproperty
    a_park_par_value: assert property (p_park_par_value) else $error("parked parity not even");

    property p_par_oe_drop;
        @(posedge clk) disable iff (!rst_n) !park.ad_oe |=> !park.par_oe;
    endproperty
    a_par_oe_drop: assert property (p_par_oe_drop) else $error("parity driven without address");

    // ****************************************
    // Cover points
    // ****************************************

    c_start:   cover property (@(posedge clk) disable iff (!rst_n) start);
    c_park:    cover property (@(posedge clk) disable iff (!rst_n) park.par_oe);
    c_serr:    cover property (@(posedge clk) disable iff (!rst_n) serr_n_oe);
    c_req_gnt: cover property (@(posedge clk) disable iff (!rst_n) !req_n ##[1:20] start);
    c_serr_ln: cover property (@(posedge clk) disable iff (!rst_n) serr_n_oe && !serr_n_in);

endmodule
`default_nettype wire

/* File: sim/up_arbiter_model.sv */
// Upstream arbiter and bus pull-up model facing the error and request block
`timescale 1ns/1ns
`default_nettype none
module up_arbiter_model #(
    parameter int GRANT_DELAY = 3
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic req_n,
    input  wire logic park_grant,
    input  wire logic serr_n_out,
    input  wire logic serr_n_oe,
    output logic      gnt_n,
    output logic      serr_wire
);
    logic [3:0] wait_reg;

    always_ff @(posedge clk) begin
        if (!rst_n || req_n) begin
            wait_reg <= 4'h0;
        end else if (wait_reg != 4'hF) begin
            wait_reg <= wait_reg + 4'h1;
        end
    end

    // Grant lags the request so a start before it shows up
    assign gnt_n = !(park_grant || (!req_n && wait_reg >= GRANT_DELAY[3:0]));
    // Pull-up keeps the shared line high unless someone pulls it low
    assign serr_wire = (serr_n_oe && !serr_n_out) ? 1'h0 : 1'h1;
endmodule
`default_nettype wire

/* File: sim/tb_upstream_error_and_bus_request.sv */
// Testbench for the upstream error and bus request block
`timescale 1ns/1ns
`default_nettype none
module tb_upstream_error_and_bus_request;
    import upsys_pkg::*;
    logic   clk, rst_n, down_serr_n_pin, serr_wire, gnt_n, frame_n, irdy_n;
    logic   need_bus, xfer_done, serr_n_out, serr_n_oe, req_n, start, park_grant, gnt_last;
    fault_s fault;
    park_s  park;
    int     err_count, num_checks;

    upsys_err_req upsys_err_req_inst (.clk(clk), .rst_n(rst_n), .fault(fault),
        .down_serr_n_pin(down_serr_n_pin), .serr_n_in(serr_wire), .gnt_n_pin(gnt_n),
        .frame_n_pin(frame_n), .irdy_n_pin(irdy_n), .need_bus(need_bus), .xfer_done(xfer_done),
        .serr_n_out(serr_n_out), .serr_n_oe(serr_n_oe), .req_n(req_n), .start(start), .park(park));
    up_arbiter_model up_arbiter_model_inst (.clk(clk), .rst_n(rst_n), .req_n(req_n),
        .park_grant(park_grant), .serr_n_out(serr_n_out), .serr_n_oe(serr_n_oe),
        .gnt_n(gnt_n), .serr_wire(serr_wire));

    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
        num_checks++;
        if (seen !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, seen);
            err_count++;
        end
    endtask

    // Bounded wait on start (0), serr_n_oe (1) or park.ad_oe (2)
    task automatic wait_lvl(input int sel, input logic lvl);
        logic v;
        for (int n = 0; n < 20; n++) begin
            gnt_last = gnt_n;
            @(negedge clk);
            v = (sel == 0) ? start : (sel == 1) ? serr_n_oe : park.ad_oe;
            if (v === lvl) return;
        end
        $display("wrong value wait %0d expected %b seen %b", sel, lvl, v);
        err_count++;
        stop_test();
    endtask

    task automatic test_faults();
        for (int i = 0; i < NUM_FAULTS; i++) begin
            fault = fault_s'(9'h001 << i);
            @(negedge clk);
            fault = '0;
            check("serr_oe", serr_n_oe, 1'h1);
            check("serr_line", serr_wire, 1'h0);
            @(negedge clk);
            check("serr_end", serr_n_oe, 1'h0);
        end
        $display("test_faults done");
    endtask

    task automatic test_down_serr();
        down_serr_n_pin = 1'h0;
        wait_lvl(1, 1'h1);
        repeat (3) @(negedge clk);
        check("serr_hold", serr_n_oe, 1'h1);
        check("serr_data", serr_n_out, 1'h0);
        down_serr_n_pin = 1'h1;
        wait_lvl(1, 1'h0);
        $display("test_down_serr done");
    endtask

    // Busy bus while granted must hold off the start
    task automatic test_request();
        logic early;
        early = 1'h0;
        need_bus = 1'h1;
        frame_n = 1'h0;
        irdy_n = 1'h0;
        @(negedge clk);
        check("req_n", req_n, 1'h0);
        repeat (12) begin
            @(negedge clk);
            early = early | start;
        end
        check("start_busy", early, 1'h0);
        check("req_held", req_n, 1'h0);
        frame_n = 1'h1;
        repeat (6) begin
            @(negedge clk);
            early = early | start;
        end
        check("start_irdy", early, 1'h0);
        irdy_n = 1'h1;
        wait_lvl(0, 1'h1);
        // Grant drops with the request, so look at the pin one cycle before start
        check("gnt_at_start", gnt_last, 1'h0);
        need_bus = 1'h0;
        xfer_done = 1'h1;
        @(negedge clk);
        xfer_done = 1'h0;
        check("start_pulse", start, 1'h0);
        repeat (6) @(negedge clk);
        $display("test_request done");
    endtask

    task automatic test_park();
        park_grant = 1'h1;
        wait_lvl(2, 1'h1);
        check("park_ad", park.ad, PARK_AD_VALUE);
        check("park_cbe", park.cbe, PARK_CBE_VALUE);
        check("park_start", start, 1'h0);
        @(negedge clk);
        check("park_par_oe", park.par_oe, 1'h1);
        check("park_par", park.par, ^{PARK_AD_VALUE, PARK_CBE_VALUE});
        park_grant = 1'h0;
        wait_lvl(2, 1'h0);
        $display("test_park done");
    endtask

    initial begin
        rst_n = 1'h0;
        fault = '0;
        down_serr_n_pin = 1'h1;
        frame_n = 1'h1;
        irdy_n = 1'h1;
        need_bus = 1'h0;
        xfer_done = 1'h0;
        park_grant = 1'h0;
        err_count = 0;
        num_checks = 0;
        repeat (3) @(negedge clk);
        rst_n = 1'h1;
        check("rst_oe", serr_n_oe, 1'h0);
        check("rst_req", req_n, !REQ_RESET);
        check("rst_park", park, 39'h0);
        repeat (4) @(negedge clk);
        test_faults();
        test_down_serr();
        test_request();
        test_park();
        stop_test();
    end
endmodule
`default_nettype wire
